// File: src/packet_input_tag_qos_stats.sv
// per-port tag configuration, diffserv and mask tables, and statistics counters
`timescale 1ns/10ps
module packet_input_tag_qos_stats (
   // clock and reset
   input  logic                                       pclk,
   input  logic                                       presetn,
   // apb slave
   input  logic                                       psel,
   input  logic                                       penable,
   input  logic                                       pwrite,
   input  logic [11:0]                                paddr,
   input  logic [31:0]                                pwdata,
   output logic [31:0]                                prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   // tag lookup
   input  packet_input_tag_qos_stats_pkg::tag_req_t   tag_req,
   output packet_input_tag_qos_stats_pkg::tag_rsp_t   tag_rsp,
   // packet engine statistics events
   input  packet_input_tag_qos_stats_pkg::stat_evt_t  stat_evt
);
   localparam int NP = packet_input_tag_qos_stats_pkg::NUM_PORTS;
   localparam int NS = packet_input_tag_qos_stats_pkg::NUM_STAT_REGS;
   localparam int NE = packet_input_tag_qos_stats_pkg::TABLE_ENTRIES;

   logic [31:0] cfg_q  [NP];
   logic [2:0]  diff_q [NE];
   logic [7:0]  mask_q [NE];
   logic [63:0] stat_q [NP*NS];
   logic        clr_on_read_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   packet_input_tag_qos_stats_pkg::tag_rsp_t tag_rsp_q;
   packet_input_tag_qos_stats_pkg::tag_rsp_t tag_rsp_d;

   logic [2:0]  region;
   logic        acc;
   logic        stall;
   logic        grant;
   logic        hit;
   logic [63:0] rd64;
   logic [6:0]  stat_idx;
   logic        sw_clear;

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign tag_rsp = tag_rsp_q;

   function automatic logic [2:0] decode(input logic [11:0] a);
      logic [2:0] r;
      r = packet_input_tag_qos_stats_pkg::RGN_NONE;
      if (a[11]) begin
         if (a[10:3] < 8'(NP*NS))
            r = packet_input_tag_qos_stats_pkg::RGN_STAT;
      end else if (a[11:9] == packet_input_tag_qos_stats_pkg::MASK_BASE[11:9]) begin
         r = packet_input_tag_qos_stats_pkg::RGN_MASK;
      end else if (a[11:9] == packet_input_tag_qos_stats_pkg::DIFF_BASE[11:9]) begin
         r = packet_input_tag_qos_stats_pkg::RGN_DIFF;
      end else if (a[11:3] == packet_input_tag_qos_stats_pkg::CTRL_OFFSET[11:3]) begin
         r = packet_input_tag_qos_stats_pkg::RGN_CTRL;
      end else if (a[11:6] == packet_input_tag_qos_stats_pkg::TAG_CFG_BASE[11:6]
                   && a[5:3] < 3'(NP)) begin
         r = packet_input_tag_qos_stats_pkg::RGN_TAG;
      end
      return r;
   endfunction

   function automatic logic [5:0] port_number(input logic [2:0] idx);
      return (idx >= 3'(packet_input_tag_qos_stats_pkg::PCI_FIRST_IDX)) ?
             6'(idx) + 6'h1d : 6'(idx);
   endfunction

   function automatic logic [31:0] inc32(input logic [31:0] x, input logic b);
      return x + {31'h0, b};
   endfunction

   // each half-word counter wraps on its own, never saturates
   function automatic logic [63:0] stat_next(input int slot, input logic [63:0] old,
                                             input packet_input_tag_qos_stats_pkg::stat_evt_t e);
      logic [15:0] l;
      logic        fcs;
      logic        in_hist;
      logic [63:0] n;
      l = e.len;
      fcs = e.fcs_err && (e.port < 3'(packet_input_tag_qos_stats_pkg::PCI_FIRST_IDX));
      in_hist = !e.short_pkt && !e.long_pkt;
      n = old;
      case (slot)
         0: n = {inc32(old[63:32], e.dropped),
                 old[31:0] + (e.dropped ? {16'h0, l} : 32'h0)};
         1: n = {16'h0, old[47:0] + {32'h0, l}};
         2: n = {inc32(old[63:32], e.processed), inc32(old[31:0], e.raw_ok)};
         3: n = {inc32(old[63:32], e.layer2_parse_mode && e.bcast),
                 inc32(old[31:0], e.layer2_parse_mode && e.mcast && !e.bcast)};
         4: n = {inc32(old[63:32], in_hist && l > packet_input_tag_qos_stats_pkg::LEN_64
                       && l < packet_input_tag_qos_stats_pkg::LEN_128),
                 inc32(old[31:0], in_hist && l == packet_input_tag_qos_stats_pkg::LEN_64)};
         5: n = {inc32(old[63:32], in_hist && l >= packet_input_tag_qos_stats_pkg::LEN_256
                       && l < packet_input_tag_qos_stats_pkg::LEN_512),
                 inc32(old[31:0], in_hist && l >= packet_input_tag_qos_stats_pkg::LEN_128
                       && l < packet_input_tag_qos_stats_pkg::LEN_256)};
         6: n = {inc32(old[63:32], in_hist && l >= packet_input_tag_qos_stats_pkg::LEN_1024
                       && l < packet_input_tag_qos_stats_pkg::LEN_1519),
                 inc32(old[31:0], in_hist && l >= packet_input_tag_qos_stats_pkg::LEN_512
                       && l < packet_input_tag_qos_stats_pkg::LEN_1024)};
         7: n = {inc32(old[63:32], fcs),
                 inc32(old[31:0], in_hist && l >= packet_input_tag_qos_stats_pkg::LEN_1519)};
         8: n = {inc32(old[63:32], e.short_pkt && fcs), inc32(old[31:0], e.short_pkt)};
         9: n = {inc32(old[63:32], e.long_pkt && fcs), inc32(old[31:0], e.long_pkt)};
         10: n = {32'h0, inc32(old[31:0], !e.has_error)};
         11: n = {16'h0, old[47:0] + {32'h0, l}};
         12: n = {48'h0, old[15:0] + {15'h0, e.has_error}};
         default: n = old;
      endcase
      return n;
   endfunction

   // apb decode and read mux
   always_comb begin
      region   = decode(paddr);
      acc      = psel && penable && !pready_q;
      stat_idx = paddr[9:3];
      stall    = (region == packet_input_tag_qos_stats_pkg::RGN_STAT) && stat_evt.valid;
      grant    = acc && !stall;
      hit      = (region != packet_input_tag_qos_stats_pkg::RGN_NONE);
      rd64     = 64'h0;
      case (region)
         packet_input_tag_qos_stats_pkg::RGN_TAG:  rd64 = {32'h0, cfg_q[paddr[5:3]]};
         packet_input_tag_qos_stats_pkg::RGN_CTRL: rd64 = {63'h0, clr_on_read_q};
         packet_input_tag_qos_stats_pkg::RGN_DIFF: rd64 = {61'h0, diff_q[paddr[8:3]]};
         packet_input_tag_qos_stats_pkg::RGN_MASK: rd64 = {56'h0, mask_q[paddr[8:3]]};
         packet_input_tag_qos_stats_pkg::RGN_STAT: rd64 = stat_q[stat_idx];
         default: rd64 = 64'h0;
      endcase
      // clear on write of either half; clear on read of the high half only
      sw_clear = grant && (region == packet_input_tag_qos_stats_pkg::RGN_STAT)
                 && (pwrite || (clr_on_read_q && paddr[2]));
   end

   // one-cycle answer; stalls while the packet engine owns the counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else if (grant) begin
         pready_q  <= 1'b1;
         pslverr_q <= !hit;
         prdata_q  <= (pwrite || !hit) ? 32'h0 : (paddr[2] ? rd64[63:32] : rd64[31:0]);
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         clr_on_read_q <= 1'b0;
      else if (grant && pwrite && !paddr[2]
               && region == packet_input_tag_qos_stats_pkg::RGN_CTRL)
         clr_on_read_q <= pwdata[packet_input_tag_qos_stats_pkg::CLR_ON_READ_BIT];
   end

   // upper words of the configuration and table entries read as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NP; i++)
            cfg_q[i] <= packet_input_tag_qos_stats_pkg::TAG_CFG_RESET;
      end else if (grant && pwrite && !paddr[2]
                   && region == packet_input_tag_qos_stats_pkg::RGN_TAG) begin
         cfg_q[paddr[5:3]] <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NE; i++)
            diff_q[i] <= packet_input_tag_qos_stats_pkg::DIFF_RESET;
      end else if (grant && pwrite && !paddr[2]
                   && region == packet_input_tag_qos_stats_pkg::RGN_DIFF) begin
         diff_q[paddr[8:3]] <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NE; i++)
            mask_q[i] <= packet_input_tag_qos_stats_pkg::MASK_RESET;
      end else if (grant && pwrite && !paddr[2]
                   && region == packet_input_tag_qos_stats_pkg::RGN_MASK) begin
         mask_q[paddr[8:3]] <= pwdata[7:0];
      end
   end

   // statistics storage: engine update first, software clear only when idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NP*NS; i++)
            stat_q[i] <= packet_input_tag_qos_stats_pkg::STAT_RESET;
      end else if (stat_evt.valid && stat_evt.port < 3'(NP)) begin
         for (int s = 0; s < NS; s++)
            stat_q[7'(s*NP) + 7'(stat_evt.port)] <=
               stat_next(s, stat_q[7'(s*NP) + 7'(stat_evt.port)], stat_evt);
      end else if (sw_clear) begin
         stat_q[stat_idx] <= packet_input_tag_qos_stats_pkg::STAT_RESET;
      end
   end

   // tag lookup, answered one cycle after the request
   always_comb begin
      logic [31:0] c;
      logic [31:0] h;
      logic        v6;
      c  = cfg_q[tag_req.port];
      v6 = tag_req.is_v6;
      h  = tag_req.tuple_hash;
      case (c[packet_input_tag_qos_stats_pkg::ALG_LSB +: 2])
         packet_input_tag_qos_stats_pkg::ALG_TUPLE:    h = tag_req.tuple_hash;
         packet_input_tag_qos_stats_pkg::ALG_MASK:     h = tag_req.mask_hash;
         packet_input_tag_qos_stats_pkg::ALG_TUPLE_IP:
            h = tag_req.is_ip ? tag_req.tuple_hash : tag_req.mask_hash;
         default: h = tag_req.tuple_hash ^ tag_req.mask_hash;
      endcase
      tag_rsp_d       = '0;
      tag_rsp_d.valid = tag_req.valid;
      tag_rsp_d.tag   = h ^ (c[packet_input_tag_qos_stats_pkg::PORT_INC_BIT] ?
                             {26'h0, port_number(tag_req.port)} : 32'h0);
      if (!tag_req.is_ip)
         tag_rsp_d.tag_type = c[packet_input_tag_qos_stats_pkg::NON_TAG_LSB +: 2];
      else if (tag_req.is_tcp)
         tag_rsp_d.tag_type = v6 ? c[packet_input_tag_qos_stats_pkg::TCP_V6_TAG_TYPE_LSB +: 2]
                                 : c[packet_input_tag_qos_stats_pkg::TCP_V4_TAG_TYPE_LSB +: 2];
      else
         tag_rsp_d.tag_type = v6 ? c[packet_input_tag_qos_stats_pkg::IPV6_OTHER_TAG_TYPE_LSB +: 2]
                                 : c[packet_input_tag_qos_stats_pkg::IPV4_OTHER_TAG_TYPE_LSB +: 2];
      tag_rsp_d.core_work_group = c[packet_input_tag_qos_stats_pkg::GRP_LSB +: 4];
      tag_rsp_d.diffserv_priority_level = diff_q[tag_req.dscp];
      // bit 7 of an entry enables the most significant byte of the word
      tag_rsp_d.byte_en = mask_q[{c[packet_input_tag_qos_stats_pkg::MASK_SEL_LSB +: 2],
                                  tag_req.word_idx}];
      if (tag_req.vlan_stacked)
         tag_rsp_d.hash_ctl.vid_sel = c[packet_input_tag_qos_stats_pkg::VID_STK_LSB +: 2];
      else
         tag_rsp_d.hash_ctl.vid_sel = c[packet_input_tag_qos_stats_pkg::VID_NOSTK_BIT] ?
            packet_input_tag_qos_stats_pkg::VID_OUTER : packet_input_tag_qos_stats_pkg::VID_NONE;
      tag_rsp_d.hash_ctl.l4_src = v6 ? c[packet_input_tag_qos_stats_pkg::V6_SPORT_BIT]
                                     : c[packet_input_tag_qos_stats_pkg::V4_SPORT_BIT];
      tag_rsp_d.hash_ctl.l4_dst = v6 ? c[packet_input_tag_qos_stats_pkg::V6_DPORT_BIT]
                                     : c[packet_input_tag_qos_stats_pkg::V4_DPORT_BIT];
      tag_rsp_d.hash_ctl.proto  = v6 ? c[packet_input_tag_qos_stats_pkg::V6_NXT_BIT]
                                     : c[packet_input_tag_qos_stats_pkg::V4_PROTO_BIT];
      tag_rsp_d.hash_ctl.dst_addr = v6 ? c[packet_input_tag_qos_stats_pkg::V6_DST_BIT]
                                       : c[packet_input_tag_qos_stats_pkg::V4_DST_BIT];
      tag_rsp_d.hash_ctl.src_addr = v6 ? c[packet_input_tag_qos_stats_pkg::V6_SRC_BIT]
                                       : c[packet_input_tag_qos_stats_pkg::V4_SRC_BIT];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tag_rsp_q <= '0;
      else
         tag_rsp_q <= tag_rsp_d;
   end

   // views of the requesting port's configuration, declared before the checks use them
   logic        c_alg_xor;
   logic [31:0] req_cfg;
   assign c_alg_xor = cfg_q[tag_req.port][29:28] == packet_input_tag_qos_stats_pkg::ALG_XOR;
   assign req_cfg   = cfg_q[tag_req.port];

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_STAT_STALL: assert property (
      (acc && region == packet_input_tag_qos_stats_pkg::RGN_STAT && stat_evt.valid)
      |=> !pready_q)
      else $error("software counter access served during a packet event");

   AST_WRITE_CLEARS: assert property (
      (sw_clear && pwrite) |=> stat_q[$past(stat_idx)] == 64'h0)
      else $error("counter not cleared by software write");

   // modulo step holds at every port-0 event, so the wrap is checked without reaching it
   AST_EVT_WRAP: assert property (
      (stat_evt.valid && stat_evt.port == 3'h0)
      |=> stat_q[7'(12*NP)][15:0]
          == 16'($past(stat_q[7'(12*NP)][15:0] + {15'h0, stat_evt.has_error})))
      else $error("error counter did not step modulo its width");

   AST_XOR_ALG: assert property (
      (tag_req.valid && c_alg_xor && !cfg_q[tag_req.port][packet_input_tag_qos_stats_pkg::PORT_INC_BIT])
      |=> tag_rsp_q.valid && tag_rsp_q.tag == $past(tag_req.tuple_hash ^ tag_req.mask_hash))
      else $error("xor tag algorithm mismatch");

   AST_GROUP: assert property (
      tag_req.valid |=> tag_rsp_q.core_work_group == $past(cfg_q[tag_req.port][3:0]))
      else $error("core group mismatch");

   AST_TCP4_TYPE: assert property (
      (tag_req.valid && tag_req.is_ip && tag_req.is_tcp && !tag_req.is_v6)
      |=> tag_rsp_q.tag_type == $past(cfg_q[tag_req.port][11:10]))
      else $error("tcp over ipv4 tag type mismatch");

   AST_QOS_LOOKUP: assert property (
      tag_req.valid |=> tag_rsp_q.diffserv_priority_level == $past(diff_q[tag_req.dscp]))
      else $error("diffserv lookup mismatch");

   AST_MASK_SET: assert property (
      tag_req.valid |=> tag_rsp_q.byte_en
         == $past(mask_q[{cfg_q[tag_req.port][31:30], tag_req.word_idx}]))
      else $error("mask set selection mismatch");

   AST_PREADY_PULSE: assert property (
      pready_q |=> !pready_q)
      else $error("pready held longer than one cycle");

   AST_RSP_VALID: assert property (
      tag_req.valid |=> tag_rsp_q.valid)
      else $error("tag answer missing");

   AST_NONIP_TYPE: assert property (
      (tag_req.valid && !tag_req.is_ip)
      |=> tag_rsp_q.tag_type == $past(req_cfg[5:4]))
      else $error("non-ip tag type mismatch");

   AST_VID_STACKED: assert property (
      (tag_req.valid && tag_req.vlan_stacked)
      |=> tag_rsp_q.hash_ctl.vid_sel == $past(req_cfg[27:26]))
      else $error("stacked vlan selection mismatch");

   AST_VID_PLAIN: assert property (
      (tag_req.valid && !tag_req.vlan_stacked)
      |=> tag_rsp_q.hash_ctl.vid_sel == {1'b0, $past(req_cfg[25])})
      else $error("unstacked vlan selection mismatch");

   AST_L4_PORTS: assert property (
      tag_req.valid |=> {tag_rsp_q.hash_ctl.l4_src, tag_rsp_q.hash_ctl.l4_dst}
         == $past(tag_req.is_v6 ? {req_cfg[21], req_cfg[23]} : {req_cfg[20], req_cfg[22]}))
      else $error("layer-4 port selection mismatch");

   AST_IP_FIELDS: assert property (
      tag_req.valid |=> {tag_rsp_q.hash_ctl.proto, tag_rsp_q.hash_ctl.dst_addr,
                         tag_rsp_q.hash_ctl.src_addr}
         == $past(tag_req.is_v6 ? {req_cfg[19], req_cfg[17], req_cfg[15]}
                                : {req_cfg[18], req_cfg[16], req_cfg[14]}))
      else $error("ip field selection mismatch");

   AST_SLVERR: assert property (
      (grant && !hit) |=> pready_q && pslverr_q)
      else $error("unmapped access not flagged");

   AST_READ_CLEARS: assert property (
      (sw_clear && !pwrite) |=> stat_q[$past(stat_idx)] == 64'h0)
      else $error("counter not cleared by read");

   AST_OCTET_ADD: assert property (
      (stat_evt.valid && stat_evt.port == 3'h0)
      |=> stat_q[7'(NP)][47:0] == 48'($past(stat_q[7'(NP)][47:0] + {32'h0, stat_evt.len})))
      else $error("octet count mismatch");

   AST_PCI_FCS: assert property (
      (stat_evt.valid && stat_evt.port == 3'h3)
      |=> $stable(stat_q[7'(7*NP+3)][63:32]))
      else $error("fcs error counted on a pci port");
endmodule

// File: src/packet_input_tag_qos_stats_pkg.sv
// constants, field layout and carrier types of the tag, qos and statistics block
package packet_input_tag_qos_stats_pkg;
   localparam int NUM_PORTS      = 5;
   localparam int NUM_STAT_REGS  = 13;
   localparam int TABLE_ENTRIES  = 64;
   localparam int PCI_FIRST_IDX  = 3;
   // byte offsets of the register regions
   localparam logic [11:0] TAG_CFG_BASE = 12'h000;
   localparam logic [11:0] CTRL_OFFSET  = 12'h040;
   localparam logic [11:0] DIFF_BASE    = 12'h200;
   localparam logic [11:0] MASK_BASE    = 12'h400;
   localparam logic [11:0] STAT_BASE    = 12'h800;
   // region codes returned by the address decoder
   localparam logic [2:0] RGN_NONE = 3'h0;
   localparam logic [2:0] RGN_TAG  = 3'h1;
   localparam logic [2:0] RGN_CTRL = 3'h2;
   localparam logic [2:0] RGN_DIFF = 3'h3;
   localparam logic [2:0] RGN_MASK = 3'h4;
   localparam logic [2:0] RGN_STAT = 3'h5;
   // port_tag_config and control register field positions
   localparam int GRP_LSB        = 0;
   localparam int NON_TAG_LSB    = 4;
   localparam int IPV4_OTHER_TAG_TYPE_LSB    = 6;
   localparam int IPV6_OTHER_TAG_TYPE_LSB    = 8;
   localparam int TCP_V4_TAG_TYPE_LSB   = 10;
   localparam int TCP_V6_TAG_TYPE_LSB   = 12;
   localparam int V4_SRC_BIT     = 14;
   localparam int V6_SRC_BIT     = 15;
   localparam int V4_DST_BIT     = 16;
   localparam int V6_DST_BIT     = 17;
   localparam int V4_PROTO_BIT   = 18;
   localparam int V6_NXT_BIT     = 19;
   localparam int V4_SPORT_BIT   = 20;
   localparam int V6_SPORT_BIT   = 21;
   localparam int V4_DPORT_BIT   = 22;
   localparam int V6_DPORT_BIT   = 23;
   localparam int PORT_INC_BIT   = 24;
   localparam int VID_NOSTK_BIT  = 25;
   localparam int VID_STK_LSB    = 26;
   localparam int ALG_LSB        = 28;
   localparam int MASK_SEL_LSB   = 30;
   localparam int CLR_ON_READ_BIT = 0;
   // reset values
   localparam logic [31:0] TAG_CFG_RESET = 32'h0000_0000;
   localparam logic [2:0]  DIFF_RESET    = 3'h0;
   localparam logic [7:0]  MASK_RESET    = 8'h00;
   localparam logic [63:0] STAT_RESET    = 64'h0;
   // tag algorithm and vlan id select codes
   localparam logic [1:0] ALG_TUPLE     = 2'h0;
   localparam logic [1:0] ALG_MASK      = 2'h1;
   localparam logic [1:0] ALG_TUPLE_IP  = 2'h2;
   localparam logic [1:0] ALG_XOR       = 2'h3;
   localparam logic [1:0] VID_OUTER     = 2'h1;
   localparam logic [1:0] VID_NONE      = 2'h0;
   // histogram bin edges in bytes
   localparam logic [15:0] LEN_64   = 16'h0040;
   localparam logic [15:0] LEN_128  = 16'h0080;
   localparam logic [15:0] LEN_256  = 16'h0100;
   localparam logic [15:0] LEN_512  = 16'h0200;
   localparam logic [15:0] LEN_1024 = 16'h0400;
   localparam logic [15:0] LEN_1519 = 16'h05ef;

   typedef struct packed {
      logic        valid;
      logic [2:0]  port;
      logic        is_ip;
      logic        is_v6;
      logic        is_tcp;
      logic        vlan_stacked;
      logic [5:0]  dscp;
      logic [3:0]  word_idx;
      logic [31:0] tuple_hash;
      logic [31:0] mask_hash;
   } tag_req_t;

   typedef struct packed {
      logic [1:0] vid_sel;
      logic       l4_src;
      logic       l4_dst;
      logic       proto;
      logic       dst_addr;
      logic       src_addr;
   } hash_ctl_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] tag;
      logic [1:0]  tag_type;
      logic [3:0]  core_work_group;
      logic [2:0]  diffserv_priority_level;
      logic [7:0]  byte_en;
      hash_ctl_t   hash_ctl;
   } tag_rsp_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  port;
      logic [15:0] len;
      logic        processed;
      logic        has_error;
      logic        fcs_err;
      logic        raw_ok;
      logic        layer2_parse_mode;
      logic        bcast;
      logic        mcast;
      logic        dropped;
      logic        short_pkt;
      logic        long_pkt;
   } stat_evt_t;
endpackage

// File: testbench/pkt_src.sv
// packet engine model that reports received packets to the statistics logic
`timescale 1ns/10ps
module pkt_src (
   // clock
   input  logic                                      pclk,
   // packet events
   output packet_input_tag_qos_stats_pkg::stat_evt_t stat_evt
);
   packet_input_tag_qos_stats_pkg::stat_evt_t e;
   initial stat_evt = '0;
   // one pulse per packet; payload scrambled once valid drops
   // fl: error, dropped, layer-2 mode, broadcast, multicast
   task automatic send(input logic [2:0] port, input logic [15:0] len, input logic [4:0] fl);
      @(posedge pclk);
      e = '{valid: 1'b1, port: port, len: len, processed: 1'b1, has_error: fl[4],
            fcs_err: fl[4], dropped: fl[3], layer2_parse_mode: fl[2], bcast: fl[1],
            mcast: fl[0], default: 1'b0};
      stat_evt <= e;
      @(posedge pclk);
      e = ~e;
      e.valid = 1'b0;
      stat_evt <= e;
   endtask
endmodule

// File: testbench/packet_input_tag_qos_stats_tb.sv
// self-checking bench for the tag, qos and statistics block
`timescale 1ns/10ps
module packet_input_tag_qos_stats_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, cfg, etag;
   logic        pready, pslverr, serr;
   logic [2:0]  dq;
   logic [7:0]  mb;
   logic [4:0]  fl;
   logic [1:0]  et;
   packet_input_tag_qos_stats_pkg::tag_req_t  tag_req = '0, r;
   packet_input_tag_qos_stats_pkg::tag_rsp_t  tag_rsp;
   packet_input_tag_qos_stats_pkg::stat_evt_t stat_evt;
   int          error_cnt = 0, checks_done = 0, seed = 71, p, ln;
   int          oct [5], drp [5], bc [5], mc [5], gd [5], er [5];
   always #2.5 pclk = ~pclk;
   packet_input_tag_qos_stats DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tag_req(tag_req), .tag_rsp(tag_rsp),
      .stat_evt(stat_evt));
   pkt_src src (.pclk(pclk), .stat_evt(stat_evt));
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // counter addresses may stall while packets arrive, so no fixed latency
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 200);
      if (n >= 200) error_cnt++;
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk_val(rd, 32'h0);
      chk_val({31'h0, serr}, 32'h0);
      apb(1'b0, 12'h200, 32'h0);
      chk_val(rd, 32'h0);
      apb(1'b0, 12'hffc, 32'h0);
      chk_val({31'h0, serr}, 32'h1);
      chk_val(rd, 32'h0);
      $display("reset and map test done");
      for (int a = 0; a < 8; a++) begin
         p = (a + 1) % 5;
         cfg = $random(seed);
         cfg[29:28] = 2'(a);
         r.tuple_hash = $random(seed);
         r.mask_hash = $random(seed);
         {r.is_ip, r.is_v6, r.is_tcp, r.vlan_stacked, r.dscp, r.word_idx} = 14'($random(seed));
         r.valid = 1'b1;
         r.port = 3'(p);
         dq = 3'($random(seed));
         mb = 8'($random(seed));
         apb(1'b1, 12'(8 * p), cfg);
         apb(1'b1, 12'h200 + 12'(8 * r.dscp), {29'h0, dq});
         apb(1'b1, 12'h400 + 12'(8 * (cfg[31:30] * 16 + r.word_idx)), {24'h0, mb});
         case (cfg[29:28])
            2'h0: etag = r.tuple_hash;
            2'h1: etag = r.mask_hash;
            2'h2: etag = r.is_ip ? r.tuple_hash : r.mask_hash;
            default: etag = r.tuple_hash ^ r.mask_hash;
         endcase
         if (cfg[24]) etag[5:0] = etag[5:0] ^ 6'(p < 3 ? p : p + 29);
         if (!r.is_ip) et = cfg[5:4];
         else if (r.is_v6) et = r.is_tcp ? cfg[13:12] : cfg[9:8];
         else et = r.is_tcp ? cfg[11:10] : cfg[7:6];
         tag_req <= r;
         @(posedge pclk);
         tag_req.valid <= 1'b0;
         #1;
         chk_val(tag_rsp.tag, etag);
         chk_val(32'(tag_rsp.tag_type), 32'(et));
         chk_val(32'(tag_rsp.core_work_group), 32'(cfg[3:0]));
         chk_val(32'(tag_rsp.diffserv_priority_level), 32'(dq));
         chk_val(32'(tag_rsp.byte_en), 32'(mb));
         chk_val(32'(tag_rsp.hash_ctl.vid_sel),
                 32'(r.vlan_stacked ? cfg[27:26] : {1'b0, cfg[25]}));
         chk_val(32'(tag_rsp.valid), 32'h1);
         chk_val(32'({tag_rsp.hash_ctl.l4_src, tag_rsp.hash_ctl.l4_dst}),
                 32'(r.is_v6 ? {cfg[21], cfg[23]} : {cfg[20], cfg[22]}));
         chk_val(32'({tag_rsp.hash_ctl.proto, tag_rsp.hash_ctl.dst_addr, tag_rsp.hash_ctl.src_addr}),
                 32'(r.is_v6 ? {cfg[19], cfg[17], cfg[15]} : {cfg[18], cfg[16], cfg[14]}));
      end
      $display("tag test done");
      for (int i = 0; i < 10; i++) begin
         ln = 64 + ($random(seed) & 2047);
         fl = 5'($random(seed));
         src.send(3'(i % 5), 16'(ln), fl);
         oct[i % 5] += ln;
         drp[i % 5] += fl[3];
         bc[i % 5] += fl[2] & fl[1];
         mc[i % 5] += fl[2] & fl[0] & !fl[1];
         gd[i % 5] += !fl[4];
         er[i % 5] += fl[4];
      end
      for (int q = 0; q < 5; q++) begin
         apb(1'b0, 12'h800 + 12'(8 * (5 + q)), 32'h0);
         chk_val(rd, 32'(oct[q]));
         apb(1'b0, 12'h800 + 12'(8 * (10 + q)) + 12'h4, 32'h0);
         chk_val(rd, 32'h2);
         apb(1'b0, 12'h800 + 12'(8 * q) + 12'h4, 32'h0);
         chk_val(rd, 32'(drp[q]));
         apb(1'b0, 12'h800 + 12'(8 * (15 + q)) + 12'h4, 32'h0);
         chk_val(rd, 32'(bc[q]));
         apb(1'b0, 12'h800 + 12'(8 * (15 + q)), 32'h0);
         chk_val(rd, 32'(mc[q]));
         apb(1'b0, 12'h800 + 12'(8 * (35 + q)) + 12'h4, 32'h0);
         chk_val(rd, 32'(q < 3 ? er[q] : 0));
         apb(1'b0, 12'h800 + 12'(8 * (50 + q)), 32'h0);
         chk_val(rd, 32'(gd[q]));
         apb(1'b0, 12'h800 + 12'(8 * (60 + q)), 32'h0);
         chk_val(rd, 32'(er[q]));
      end
      // packet lands during the access phase, so the read must wait and include it
      fork
         begin
            @(posedge pclk);
            src.send(3'h0, 16'h0064, 5'h00);
         end
         apb(1'b0, 12'h828, 32'h0);
      join
      chk_val(rd, 32'(oct[0] + 100));
      apb(1'b1, 12'h828, 32'h0);
      apb(1'b0, 12'h828, 32'h0);
      chk_val(rd, 32'h0);
      apb(1'b1, 12'h040, 32'h1);
      apb(1'b0, 12'h85c, 32'h0);
      chk_val(rd, 32'h2);
      apb(1'b0, 12'h85c, 32'h0);
      chk_val(rd, 32'h0);
      $display("statistics test done");
      end_sim;
   end
   initial begin
      #100000;
      error_cnt++;
      end_sim;
   end
endmodule
